// [design/fhr_pkg.sv]
// What this block does
// R1 - First mode: status A bit 7 is interrupt level, bit 6 low if drive two
// R2 - First mode: A5 not step, A4 track zero, A3 not side, A2 index
// R3 - First mode: A1 low when write protected, A0 high for inward motion
// R4 - Alternate mode: A7 interrupt, A6 DMA request, A5 not latched step
// R5 - Alternate mode: A4 not track zero pin, A3 side, A2 not index, A1, A0
// R6 - First mode: status B bit 5 mirrors drive select bit 0
// R7 - First mode: B4 toggles per write pulse rise, B3 per read data rise
// R8 - First mode: B2 not write gate, B1 and B0 motor B and A enables
// R9 - Alternate mode: B7 low if second drive, B6 B5 drive select pins
// R10 - Alternate mode: B4..B2 inverses of write, read and gate latches
// R11 - Alternate mode: B1 low when drive D selected, B0 for drive C
// R12 - Drive output register is write only and cleared by master reset
// R13 - Tape register shows only tape select unless three mode enabled
// R14 - Three mode: tape bits 7-6 media ID, bits 3-2 boot drive copies
// R15 - Three mode: tape bits 5-4 drive type pair of last selected drive
// R16 - Tape select 00 none, 01..11 drives 1..3; drive 0 never tape
// R17 - Effective rate follows the latest rate or config control write
// R18 - Rate register bit 7 software reset, bit 6 power down
// R19 - Precomp code picks delay; 000 default, 001..110 steps, 111 off
// R20 - Default delay 125 ns up to 500k, 41.67 ns 1M, 20.8 ns 2M
// R21 - Rate bits pick data rate and reduced write current level
// R22 - Software sets rate 01 and rate table 10 for 2 Mb/s tape
// R23 - Data port carries command traffic; FIFO disabled after reset
package fhr_pkg;
   // Register indices; byte address is four times the index
   localparam logic [3:0] FHR_IDX_STAT_A = 4'h0;
   localparam logic [3:0] FHR_IDX_STAT_B = 4'h1;
   localparam logic [3:0] FHR_IDX_DOR    = 4'h2;
   localparam logic [3:0] FHR_IDX_TAPE   = 4'h3;
   localparam logic [3:0] FHR_IDX_RATE   = 4'h4;
   localparam logic [3:0] FHR_IDX_DATA   = 4'h5;
   localparam logic [3:0] FHR_IDX_CCR    = 4'h7;
   localparam logic [3:0] FHR_IDX_CFG    = 4'h8;
   // Field positions
   localparam int FHR_DOR_RESET_N = 2;
   localparam int FHR_DOR_DMA_EN  = 3;
   localparam int FHR_DOR_MOT_A   = 4;
   localparam int FHR_DOR_MOT_B   = 5;
   localparam int FHR_DR_SWRST    = 7;
   localparam int FHR_DR_PDOWN    = 6;
   localparam int FHR_CFG_3MODE   = 0;
   localparam int FHR_CFG_ALT     = 1;
   localparam int FHR_CFG_TBL     = 2;
   localparam int FHR_CFG_MEDIA   = 8;
   localparam int FHR_CFG_DTYPE   = 16;
   // Reset values and rate or table codes
   localparam logic [7:0]  FHR_DOR_RST  = 8'h00;
   localparam logic [23:0] FHR_CFG_RST  = 24'h000000;
   localparam logic [1:0]  FHR_RATE_RST = 2'h0;
   localparam logic [1:0]  FHR_TBL_2M   = 2'h2;
   localparam logic [1:0]  FHR_RATE_2M  = 2'h1;
   localparam logic [1:0]  FHR_RATE_1M  = 2'h3;
   // Precompensation delays in picoseconds, codes 001..110
   localparam logic [17:0] FHR_PRE_STD [0:5] =
      '{18'h0A2C6, 18'h1458C, 18'h1E848, 18'h28B0E, 18'h32DCA, 18'h3D090};
   localparam logic [17:0] FHR_PRE_2M [0:5] =
      '{18'h05140, 18'h0A0D2, 18'h0F424, 18'h14564, 18'h19708, 18'h1E848};
   localparam logic [17:0] FHR_DEF_STD = 18'h1E848;
   localparam logic [17:0] FHR_DEF_1M  = 18'h0A2C6;
   localparam logic [17:0] FHR_DEF_2M  = 18'h05140;

   // Drive interface pins seen by the register file
   typedef struct packed {
      logic irq;
      logic dma_request_out;
      logic step;
      logic track_zero_in_n;
      logic head;
      logic index;
      logic write_protect;
      logic dir_inward;
      logic read_data;
      logic write_pulse_pin_n;
      logic write_gate_n;
      logic second_drive_absent;
   } fhr_pins_type;

   // Drive controls driven by the register file
   typedef struct packed {
      logic        motor_a_pin_n;
      logic        motor_b_pin_n;
      logic        motor_c_on;
      logic        motor_d_on;
      logic        drive_a_select_pin_n;
      logic        drive_b_select_pin_n;
      logic [1:0]  drive_sel;
      logic        dma_irq_enable;
      logic        ctrl_reset_n;
      logic        soft_reset;
      logic        power_down;
      logic [1:0]  rate_sel;
      logic        reduced_write_current;
      logic [17:0] precomp_ps;
      logic [1:0]  tape_sel;
   } fhr_drive_type;
endpackage

// [design/fhr_regs.sv]
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
module fhr_regs
   import fhr_pkg::*;
(
   input  wire logic          core_clk,
   input  wire logic          reset,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire fhr_pins_type  pins,
   input  wire logic [7:0]    main_flow_status,
   input  wire logic [7:0]    fifo_rd_data,
   input  wire logic          fifo_cfg_load,
   input  wire logic          fifo_cfg_on,
   output fhr_drive_type      drive,
   output logic [7:0]         cmd_wr_data,
   output logic               cmd_wr_pulse,
   output logic               cmd_rd_pulse,
   output logic               fifo_enabled
);

   // Precomp lookup; 2 Mb/s tape uses the halved column
   function automatic logic [17:0] fhr_precomp(input logic [2:0] code,
                                               input logic [1:0] rate,
                                               input logic       tape2m);
      logic [17:0] ps;
      ps = 18'h00000;
      if (code == 3'h0) begin
         ps = tape2m ? FHR_DEF_2M : (rate == FHR_RATE_1M) ? FHR_DEF_1M : FHR_DEF_STD; // R20
      end else if (code != 3'h7) begin
         ps = tape2m ? FHR_PRE_2M[code - 3'h1] : FHR_PRE_STD[code - 3'h1]; // R19
      end
      return ps;
   endfunction

   logic [7:0]  dor_reg;
   logic [1:0]  tape_sel_reg;
   logic [23:0] cfg_reg;
   logic [1:0]  rate_reg;
   logic [2:0]  precomp_code_reg;
   logic        pdown_reg;
   logic        swrst_reg;
   logic [17:0] precomp_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rdata_next;
   logic [7:0]  stat_a_next;
   logic [7:0]  stat_b_next;
   logic [7:0]  tape_next;
   logic        step_prev_reg;
   logic        wd_prev_reg;
   logic        rd_prev_reg;
   logic        wd_tog_reg;
   logic        rd_tog_reg;
   logic        step_ff_reg;
   logic        wd_ff_reg;
   logic        rd_ff_reg;
   logic        we_ff_reg;
   logic        fifo_en_reg;
   logic [7:0]  cmd_data_reg;
   logic        cmd_wr_reg;
   logic        cmd_rd_reg;
   logic [3:0]  idx;
   logic        hit;
   logic        setup;
   logic        access;
   logic        wr;
   logic        rd;
   logic        alt_mode;
   logic        three_mode;
   logic [1:0]  sel;
   logic        step_rise;
   logic        wd_rise;
   logic        rd_rise;
   logic        tape2m;

   // Bus decode; zero wait states, read data captured in the setup cycle
   assign idx    = paddr[5:2];
   assign hit    = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) &&
                   ((idx <= FHR_IDX_DATA) || (idx == FHR_IDX_CCR) || (idx == FHR_IDX_CFG));
   assign setup  = psel && !penable;
   assign access = psel && penable;
   assign wr     = access && pwrite && hit;
   assign rd     = access && !pwrite && hit;
   assign pready  = access;
   assign pslverr = access && !hit;
   assign prdata  = prdata_reg;

   assign alt_mode   = cfg_reg[FHR_CFG_ALT];
   assign three_mode = cfg_reg[FHR_CFG_3MODE];
   assign sel        = dor_reg[1:0];
   assign tape2m     = (rate_reg == FHR_RATE_2M) &&
                       (cfg_reg[FHR_CFG_TBL +: 2] == FHR_TBL_2M); // R22
   assign step_rise  = pins.step && !step_prev_reg;
   assign wd_rise    = pins.write_pulse_pin_n && !wd_prev_reg;
   assign rd_rise    = pins.read_data && !rd_prev_reg;

   // Drive outputs; pins are active low selects and motors A and B, motors C and D active high
   always_comb begin
      drive.motor_a_pin_n         = !dor_reg[FHR_DOR_MOT_A];
      drive.motor_b_pin_n         = !dor_reg[FHR_DOR_MOT_B];
      drive.motor_c_on            = dor_reg[6];
      drive.motor_d_on            = dor_reg[7];
      drive.drive_a_select_pin_n  = (sel != 2'h0);
      drive.drive_b_select_pin_n  = (sel != 2'h1);
      drive.drive_sel             = sel;
      drive.dma_irq_enable        = dor_reg[FHR_DOR_DMA_EN];
      drive.ctrl_reset_n          = dor_reg[FHR_DOR_RESET_N];
      drive.soft_reset            = swrst_reg;
      drive.power_down            = pdown_reg;
      drive.rate_sel              = rate_reg;
      drive.reduced_write_current = !(rate_reg[1] ^ rate_reg[0]); // R21
      drive.precomp_ps            = precomp_reg;
      drive.tape_sel              = tape_sel_reg;
   end

   // Status A in both modes
   always_comb begin
      if (!alt_mode) begin
         stat_a_next = {pins.irq, pins.second_drive_absent, !pins.step, // R1
                        pins.track_zero_in_n, !pins.head, pins.index,    // R2
                        !pins.write_protect, pins.dir_inward};           // R3
      end else begin
         stat_a_next = {pins.irq, pins.dma_request_out, !step_ff_reg,   // R4
                        !pins.track_zero_in_n, pins.head, !pins.index,   // R5
                        pins.write_protect, !pins.dir_inward};           // R5
      end
   end

   // Status B; unused high bits of the first mode read as ones
   always_comb begin
      if (!alt_mode) begin
         stat_b_next = {2'h3, sel[0],                                    // R6
                        wd_tog_reg, rd_tog_reg,                          // R7
                        !pins.write_gate_n, dor_reg[FHR_DOR_MOT_B],      // R8
                        dor_reg[FHR_DOR_MOT_A]};                         // R8
      end else begin
         stat_b_next = {pins.second_drive_absent,                        // R9
                        drive.drive_b_select_pin_n, drive.drive_a_select_pin_n,
                        !wd_ff_reg, !rd_ff_reg, !we_ff_reg,              // R10
                        (sel != 2'h3), (sel != 2'h2)};                   // R11
      end
   end

   // Tape register; extra fields hidden outside three mode
   always_comb begin
      tape_next = {6'h00, tape_sel_reg};                                 // R13
      if (three_mode) begin
         tape_next = {cfg_reg[FHR_CFG_MEDIA + 4], cfg_reg[FHR_CFG_MEDIA + 5], // R14
                      cfg_reg[FHR_CFG_DTYPE + {sel, 1'b1}],              // R15
                      cfg_reg[FHR_CFG_DTYPE + {sel, 1'b0}],              // R15
                      cfg_reg[FHR_CFG_MEDIA + 7], cfg_reg[FHR_CFG_MEDIA + 6], // R14
                      tape_sel_reg};
      end
   end

   // Read mux; write only locations read as zero
   always_comb begin
      rdata_next = 32'h00000000;
      if (hit) begin
         unique case (idx)
            FHR_IDX_STAT_A: rdata_next[7:0] = stat_a_next;
            FHR_IDX_STAT_B: rdata_next[7:0] = stat_b_next;
            FHR_IDX_TAPE:   rdata_next[7:0] = tape_next;
            FHR_IDX_RATE:   rdata_next[7:0] = main_flow_status;
            FHR_IDX_DATA:   rdata_next[7:0] = fifo_rd_data;
            FHR_IDX_CFG:    rdata_next[23:0] = cfg_reg;
            default:        rdata_next = 32'h00000000;
         endcase
      end
   end

   // Read data held from setup through the access cycle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         prdata_reg <= 32'h00000000;
      end else if (setup && !pwrite) begin
         prdata_reg <= rdata_next;
      end
   end

   // Drive output register, cleared by master reset only
   always_ff @(posedge core_clk) begin
      if (reset) begin
         dor_reg <= FHR_DOR_RST; // R12
      end else if (wr && idx == FHR_IDX_DOR) begin
         dor_reg <= pwdata[7:0];
      end
   end

   // Tape select and local configuration
   always_ff @(posedge core_clk) begin
      if (reset) begin
         tape_sel_reg <= 2'h0;
         cfg_reg      <= FHR_CFG_RST;
      end else begin
         if (wr && idx == FHR_IDX_TAPE) begin
            tape_sel_reg <= pwdata[1:0]; // R16
         end
         if (wr && idx == FHR_IDX_CFG) begin
            cfg_reg <= pwdata[23:0];
         end
      end
   end

   // Rate follows whichever of the two registers was written last
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rate_reg <= FHR_RATE_RST;
      end else if (wr && (idx == FHR_IDX_RATE || idx == FHR_IDX_CCR)) begin
         rate_reg <= pwdata[1:0]; // R17
      end
   end

   // Rate register side fields; soft reset is a single pulse
   always_ff @(posedge core_clk) begin
      if (reset) begin
         precomp_code_reg <= 3'h0;
         pdown_reg        <= 1'b0;
         swrst_reg        <= 1'b0;
      end else begin
         swrst_reg <= wr && idx == FHR_IDX_RATE && pwdata[FHR_DR_SWRST]; // R18
         if (wr && idx == FHR_IDX_RATE) begin
            pdown_reg        <= pwdata[FHR_DR_PDOWN]; // R18
            precomp_code_reg <= pwdata[4:2];
         end
      end
   end

   // Registered precomp so the delay output is glitch free
   always_ff @(posedge core_clk) begin
      if (reset) begin
         precomp_reg <= FHR_DEF_STD;
      end else begin
         precomp_reg <= fhr_precomp(precomp_code_reg, rate_reg, tape2m); // R19
      end
   end

   // Edge history of the monitored pins
   always_ff @(posedge core_clk) begin
      if (reset) begin
         step_prev_reg <= 1'b0;
         wd_prev_reg   <= 1'b1;
         rd_prev_reg   <= 1'b0;
      end else begin
         step_prev_reg <= pins.step;
         wd_prev_reg   <= pins.write_pulse_pin_n;
         rd_prev_reg   <= pins.read_data;
      end
   end

   // Toggles for the first mode
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wd_tog_reg <= 1'b0;
         rd_tog_reg <= 1'b0;
      end else begin
         wd_tog_reg <= wd_tog_reg ^ wd_rise; // R7
         rd_tog_reg <= rd_tog_reg ^ rd_rise; // R7
      end
   end

   // Sticky latches, cleared by reading their status register; set wins
   always_ff @(posedge core_clk) begin
      if (reset) begin
         step_ff_reg <= 1'b0;
         wd_ff_reg   <= 1'b0;
         rd_ff_reg   <= 1'b0;
         we_ff_reg   <= 1'b0;
      end else begin
         step_ff_reg <= step_rise || (step_ff_reg && !(rd && idx == FHR_IDX_STAT_A));
         wd_ff_reg   <= wd_rise || (wd_ff_reg && !(rd && idx == FHR_IDX_STAT_B)); // R10
         rd_ff_reg   <= rd_rise || (rd_ff_reg && !(rd && idx == FHR_IDX_STAT_B));
         we_ff_reg   <= !pins.write_gate_n || (we_ff_reg && !(rd && idx == FHR_IDX_STAT_B));
      end
   end

   // Data port strobes toward the command sequencer
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cmd_data_reg <= 8'h00;
         cmd_wr_reg   <= 1'b0;
         cmd_rd_reg   <= 1'b0;
      end else begin
         cmd_wr_reg <= wr && idx == FHR_IDX_DATA; // R23
         cmd_rd_reg <= rd && idx == FHR_IDX_DATA;
         if (wr && idx == FHR_IDX_DATA) begin
            cmd_data_reg <= pwdata[7:0];
         end
      end
   end

   // FIFO stays off until the configure command turns it on
   always_ff @(posedge core_clk) begin
      if (reset) begin
         fifo_en_reg <= 1'b0; // R23
      end else if (fifo_cfg_load) begin
         fifo_en_reg <= fifo_cfg_on;
      end
   end

   assign cmd_wr_data  = cmd_data_reg;
   assign cmd_wr_pulse = cmd_wr_reg;
   assign cmd_rd_pulse = cmd_rd_reg;
   assign fifo_enabled = fifo_en_reg;

   // Checks
   sequence s_rd_setup(logic [3:0] r);
      setup && !pwrite && hit && idx == r;
   endsequence

   chk_dor_reset_clear: assert property (@(posedge core_clk) // R12
      reset |=> dor_reg == 8'h00 && drive.motor_a_pin_n && !drive.ctrl_reset_n)
      else $error("drive output register not cleared by reset");

   chk_stat_a_first: assert property (@(posedge core_clk) disable iff (reset) // R2
      s_rd_setup(FHR_IDX_STAT_A) ##0 !alt_mode ##1 access |->
      prdata[5] == !$past(pins.step) && prdata[7] == $past(pins.irq))
      else $error("status A first mode step or irq wrong");

   chk_stat_a_alt: assert property (@(posedge core_clk) disable iff (reset) // R5
      s_rd_setup(FHR_IDX_STAT_A) ##0 alt_mode ##1 access |->
      prdata[4] == !$past(pins.track_zero_in_n) && prdata[0] == !$past(pins.dir_inward))
      else $error("status A alternate mode track or dir wrong");

   chk_wd_toggle: assert property (@(posedge core_clk) disable iff (reset) // R7
      wd_rise |=> wd_tog_reg != $past(wd_tog_reg))
      else $error("write pulse toggle missed an edge");

   chk_latch_hold: assert property (@(posedge core_clk) disable iff (reset) // R10
      wd_rise ##1 !(rd && idx == FHR_IDX_STAT_B) |=> wd_ff_reg)
      else $error("write pulse latch lost before read");

   chk_rate_last: assert property (@(posedge core_clk) disable iff (reset) // R17
      wr && (idx == FHR_IDX_CCR || idx == FHR_IDX_RATE) |=> ##1
      drive.rate_sel == $past(pwdata[1:0], 2))
      else $error("rate does not follow latest write");

   chk_swrst_pulse: assert property (@(posedge core_clk) disable iff (reset) // R18
      wr && idx == FHR_IDX_RATE && pwdata[FHR_DR_SWRST] |=> drive.soft_reset ##1
      !drive.soft_reset || $past(wr))
      else $error("software reset is not a one cycle pulse");

   chk_rwc_map: assert property (@(posedge core_clk) disable iff (reset) // R21
      drive.rate_sel inside {2'h1, 2'h2} |-> !drive.reduced_write_current)
      else $error("reduced write current level wrong for rate");

   chk_precomp_off: assert property (@(posedge core_clk) disable iff (reset) // R19
      precomp_code_reg == 3'h7 |=> precomp_reg == 18'h00000)
      else $error("precomp not disabled for code 7");

   chk_tape_hidden: assert property (@(posedge core_clk) disable iff (reset) // R13
      s_rd_setup(FHR_IDX_TAPE) ##0 !three_mode |=> prdata[7:2] == 6'h00)
      else $error("tape extra fields visible outside three mode");

   chk_fifo_off: assert property (@(posedge core_clk) // R23
      reset |=> !fifo_enabled)
      else $error("FIFO enabled after reset");

endmodule

// [dv/fhr_drive_model.sv]
`timescale 1ns/10ps
// Drive side stand-in: pins arrive one clock late, as through input flops
module fhr_drive_model
   import fhr_pkg::*;
(
   input  wire logic          core_clk,
   input  wire logic          reset,
   input  wire fhr_pins_type  pin_req,
   output fhr_pins_type       pins
);
   // Idle during reset: active-low lines high
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pins <= 12'h106;
      end else begin
         pins <= pin_req;
      end
   end
endmodule

// [dv/fhr_tb.sv]
`timescale 1ns/10ps
module tb
   import fhr_pkg::*;
();
   localparam fhr_pins_type PIN_IDLE = 12'h106;
   logic          core_clk = 1'b0;
   logic          reset = 1'b1;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic [7:0]    paddr = 8'h00;
   logic [31:0]   pwdata = 32'h0;
   logic [7:0]    main_flow_status = 8'h5A;
   logic [7:0]    fifo_rd_data = 8'hA5;
   logic          fifo_cfg_load = 1'b0;
   logic          fifo_cfg_on = 1'b0;
   fhr_pins_type  pin_req = PIN_IDLE;
   fhr_pins_type  pins;
   fhr_drive_type drive;
   logic [31:0]   prdata;
   logic          pready;
   logic          pslverr;
   logic [7:0]    cmd_wr_data;
   logic          cmd_wr_pulse;
   logic          cmd_rd_pulse;
   logic          fifo_enabled;
   int            n_mismatch = 0;
   int            total_checks = 0;
   logic [31:0]   r;
   logic [31:0]   r0;
   logic          e;
   logic [11:0]   pc;
   fhr_pins_type  p;

   // Core clock, 100 MHz
   always #5 core_clk = ~core_clk;

   fhr_regs fhr_regs_i (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins(pins), .main_flow_status(main_flow_status),
      .fifo_rd_data(fifo_rd_data), .fifo_cfg_load(fifo_cfg_load), .fifo_cfg_on(fifo_cfg_on),
      .drive(drive), .cmd_wr_data(cmd_wr_data), .cmd_wr_pulse(cmd_wr_pulse),
      .cmd_rd_pulse(cmd_rd_pulse), .fifo_enabled(fifo_enabled));

   fhr_drive_model fhr_drive_model_i (.core_clk(core_clk), .reset(reset),
      .pin_req(pin_req), .pins(pins));

   // Verdict; also the exit of a hung wait
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Case equality, so unknowns never match
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One APB transfer, held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd_v, output logic err);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         n_mismatch++;
         end_of_test();
      end
      rd_v = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle;
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r0, e);
   endtask

   // Write, let outputs land
   task automatic wrs(input logic [7:0] a, input logic [31:0] d);
      wr(a, d);
      settle();
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      apb(1'b0, a, 32'h0, v, e);
      chk("pslverr", 32'h0, 32'(e));
   endtask

   // Model shows pins one clock late
   task automatic setp(input fhr_pins_type v);
      @(posedge core_clk);
      pin_req <= v;
      repeat (3) @(posedge core_clk);
   endtask

   // Nibble counts of soft reset, command write, command read
   task automatic pulse_cnt(output logic [11:0] c);
      c = 12'h000;
      repeat (4) begin
         #1;
         c = c + {3'h0, drive.soft_reset, 3'h0, cmd_wr_pulse, 3'h0, cmd_rd_pulse};
         @(posedge core_clk);
      end
   endtask

   function automatic logic [31:0] exp_a(input fhr_pins_type v, input logic alt);
      if (alt) begin
         return {24'h0, v.irq, v.dma_request_out, 1'b1, ~v.track_zero_in_n, v.head,
                 ~v.index, v.write_protect, ~v.dir_inward};
      end
      return {24'h0, v.irq, v.second_drive_absent, ~v.step, v.track_zero_in_n, ~v.head,
              v.index, ~v.write_protect, v.dir_inward};
   endfunction

   // Status A both modes, step latch and clear
   task automatic t_stat_a;
      p = PIN_IDLE | 12'hA50; // Irq, step, index, inward
      for (int i = 0; i < 2; i++) begin
         setp(p);
         rd(8'h00, r);
         chk("status_a_first", exp_a(p, 1'b0), r);
         p = ~p;
      end
      wr(8'h20, 32'h2);
      for (int i = 0; i < 2; i++) begin
         p = ~p;
         p.step = 1'b0;
         setp(p);
         rd(8'h00, r);
         rd(8'h00, r);
         chk("status_a_alt", exp_a(p, 1'b1), r);
      end
      p.step = 1'b1;
      setp(p);
      p.step = 1'b0;
      setp(p);
      rd(8'h00, r);
      chk("step_latch", exp_a(p, 1'b1) & 32'hDF, r);
      rd(8'h00, r);
      chk("step_latch_clr", exp_a(p, 1'b1), r);
      setp(PIN_IDLE);
      $display("test status_a done");
   endtask

   // Status B first mode
   task automatic t_stat_b_first;
      wr(8'h20, 32'h0);
      wr(8'h08, 32'h31);
      rd(8'h04, r0);
      chk("status_b_first", 32'hE3, r0 & 32'hFFFFFFE7);
      p = PIN_IDLE;
      p.write_pulse_pin_n = 1'b0;
      setp(p);
      setp(PIN_IDLE);
      rd(8'h04, r);
      chk("wd_toggle", r0 ^ 32'h10, r);
      p = PIN_IDLE;
      p.read_data = 1'b1;
      p.write_gate_n = 1'b0;
      setp(p);
      p.read_data = 1'b0;
      setp(p);
      rd(8'h04, r0);
      chk("rd_toggle_gate", r ^ 32'h0C, r0);
      setp(PIN_IDLE);
      $display("test status_b_first done");
   endtask

   // Status B alternate mode
   task automatic t_stat_b_alt;
      wr(8'h20, 32'h2);
      for (int i = 0; i < 4; i++) begin
         p = PIN_IDLE;
         p.second_drive_absent = i[0];
         setp(p);
         wr(8'h08, 32'(i));
         rd(8'h04, r);
         rd(8'h04, r);
         chk("status_b_alt", {24'h0, i[0], i != 1, i != 0, 3'h7, i != 3, i != 2}, r);
      end
      p.write_pulse_pin_n = 1'b0;
      p.write_gate_n = 1'b0;
      p.read_data = 1'b1;
      setp(p);
      setp(PIN_IDLE);
      rd(8'h04, r);
      chk("b_latches", 32'h61, r);
      rd(8'h04, r);
      chk("b_latch_clr", 32'h7D, r);
      $display("test status_b_alt done");
   endtask

   // Tape register, both layouts
   task automatic t_tape;
      wr(8'h20, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(8'h0C, 32'hFC | 32'(i));
         rd(8'h0C, r);
         chk("tape_normal", 32'(i), r);
         chk("tape_sel", 32'(i), 32'(drive.tape_sel));
      end
      wr(8'h20, 32'h00E4D001);
      for (int i = 0; i < 4; i++) begin
         wr(8'h08, 32'(i));
         rd(8'h0C, r);
         chk("tape_3mode", 32'h8F | 32'(i << 4), r);
      end
      $display("test tape done");
   endtask

   // Rate register fields
   task automatic t_rate;
      wr(8'h20, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wrs(8'h10, 32'(i));
         chk("rate_sel", 32'(i), 32'(drive.rate_sel));
         chk("rwc", 32'(i == 0 || i == 3), 32'(drive.reduced_write_current));
         chk("precomp_def", (i == 3) ? FHR_DEF_1M : FHR_DEF_STD, drive.precomp_ps);
      end
      for (int c = 1; c < 8; c++) begin
         wrs(8'h10, 32'(c << 2));
         chk("precomp", (c == 7) ? 18'h0 : FHR_PRE_STD[c - 1], drive.precomp_ps);
      end
      wrs(8'h1C, 32'h2);
      chk("rate_ccr", 32'h2, 32'(drive.rate_sel));
      wrs(8'h10, 32'h1);
      chk("rate_dr", 32'h1, 32'(drive.rate_sel));
      wrs(8'h20, 32'h8);
      chk("precomp_2m", FHR_DEF_2M, drive.precomp_ps);
      for (int c = 1; c < 7; c++) begin
         wrs(8'h10, 32'(c << 2) | 32'h1);
         chk("precomp_2m", FHR_PRE_2M[c - 1], drive.precomp_ps);
      end
      wr(8'h10, 32'h80);
      pulse_cnt(pc);
      chk("soft_reset", 32'h100, 32'(pc));
      wrs(8'h10, 32'h40);
      chk("power_down", 32'h1, 32'(drive.power_down));
      wrs(8'h10, 32'h0);
      chk("power_up", 32'h0, 32'(drive.power_down));
      $display("test rate done");
   endtask

   // Data port, FIFO enable, refused addresses
   task automatic t_data;
      rd(8'h10, r);
      chk("main_status", 32'h5A, r);
      wr(8'h14, 32'hC3);
      pulse_cnt(pc);
      chk("cmd_wr", 32'h010, 32'(pc));
      chk("cmd_wr_data", 32'hC3, 32'(cmd_wr_data));
      rd(8'h14, r);
      chk("data_rd", 32'hA5, r);
      pulse_cnt(pc);
      chk("cmd_rd", 32'h001, 32'(pc));
      chk("fifo_off", 32'h0, 32'(fifo_enabled));
      fifo_cfg_load <= 1'b1;
      fifo_cfg_on <= 1'b1;
      @(posedge core_clk);
      fifo_cfg_load <= 1'b0;
      settle();
      chk("fifo_on", 32'h1, 32'(fifo_enabled));
      for (int i = 0; i < 4; i++) begin
         apb(i[0], (i < 2) ? 8'h18 : 8'h40 + 8'(i), 32'hFF, r, e);
         chk("unmapped_err", 32'h1, 32'(e));
      end
      $display("test data done");
   endtask

   // Drive output fields (top ten bits), then master reset
   task automatic t_dor;
      wrs(8'h08, 32'hFF);
      chk("dor_set", 32'h0FF, 32'(drive[34:25]));
      rd(8'h08, r);
      chk("dor_wo", 32'h0, r);
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      #1;
      chk("dor_reset", 32'h310, 32'(drive[34:25]));
      chk("dor_sel", 32'h0, 32'(drive.drive_sel));
      $display("test dor done");
   endtask

   // Main sequence
   initial begin
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      settle();
      chk("dor_init", 32'h310, 32'(drive[34:25]));
      chk("precomp_init", FHR_DEF_STD, drive.precomp_ps);
      chk("fifo_init", 32'h0, 32'(fifo_enabled));
      t_stat_a();
      t_stat_b_first();
      t_stat_b_alt();
      t_tape();
      t_rate();
      t_data();
      t_dor();
      end_of_test();
   end
endmodule
